/* File: design/phs_auto_shed.sv */
// Auto phase shedding controller with boot refresh of dropped phases.
`timescale 1ns/1ps
`default_nettype none
module phs_auto_shed
	import phs_pkg::*;
(
	input wire logic clk_sys, // System clock, 10 MHz.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic [7:0] reg_addr, // Register command code.
	input wire logic reg_wr, // Write strobe.
	input wire logic [7:0] reg_wdata, // Write data.
	output logic [7:0] reg_rdata, // Read data, registered.
	input wire logic [9:0] load_current_monitor, // Digitised load current.
	input wire logic [1:0] low_power_phase_count, // Low-power-state-one phase count.
	input wire logic threshold_pin_gnd, // Threshold pin sensed at ground.
	input wire logic [MAX_PHASES-1:0] pwm_tied_high, // PWM pins sensed at supply.
	input wire logic soft_start_done, // Soft-start has finished.
	input wire logic transient_phase_add, // Fast load-transient detector pulse.
	input wire logic ocp_retry, // Overcurrent retry pulse.
	input wire logic [10:0] dac_mv, // Reference DAC level in millivolts.
	output logic [MAX_PHASES-1:0] phase_enable, // Phase runs PWM.
	output logic [MAX_PHASES-1:0] low_side_refresh // Low-side refresh pulse.
);
	logic [7:0] phase_count_r;
	phs_cfg_t phase_shed_config_r;
	logic [7:0] mode_control_r;
	logic [4:0] monitor_offset_trim_r;
	logic [2:0] active_r;
	logic [2:0] active_nxt;
	logic [2:0] populated_r;
	logic [1:0] strap_cnt_r;
	logic strap_done_r;
	logic [MAX_PHASES-1:0] tie_s1_r;
	logic [MAX_PHASES-1:0] tie_s2_r;
	logic gnd_s1_r;
	logic gnd_s2_r;
	logic [4:0] dwell_r;
	logic [8:0] refresh_cnt_r;
	logic refresh_pulse;
	logic [11:0] monitor_trim;
	logic [2:0] min_phases;
	logic [2:0] manual_target;
	logic auto_on;
	logic restore_all;
	phs_trip_t trip;

	// Register writes; the configuration steers the shedding logic directly.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			phase_count_r <= PHASE_COUNT_RST;
			phase_shed_config_r <= PHASE_SHED_CONFIG_RST;
			mode_control_r <= MODE_CONTROL_RST;
			monitor_offset_trim_r <= MONITOR_OFFSET_TRIM_RST[TRIM_MSB:0];
		end else if (reg_wr) begin
			unique case (reg_addr)
				PHASE_COUNT_OFS: phase_count_r <= reg_wdata;
				PHASE_SHED_CONFIG_OFS: phase_shed_config_r <= reg_wdata;
				MODE_CONTROL_OFS: mode_control_r <= reg_wdata;
				MONITOR_OFFSET_TRIM_OFS: monitor_offset_trim_r <= reg_wdata[TRIM_MSB:0];
				default: ;
			endcase
		end
	end

	// Registered read mux; unmapped codes read as zero.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else begin
			unique case (reg_addr)
				PHASE_COUNT_OFS: reg_rdata <= phase_count_r;
				PHASE_SHED_CONFIG_OFS: reg_rdata <= phase_shed_config_r;
				SHED_STATUS_OFS: reg_rdata <= {auto_on, 1'b0, populated_r, active_r};
				MODE_CONTROL_OFS: reg_rdata <= mode_control_r;
				MONITOR_OFFSET_TRIM_OFS: reg_rdata <= {3'h0, monitor_offset_trim_r};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Pin inputs pass two flip-flops before anything reads them.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tie_s1_r <= '0;
			tie_s2_r <= '0;
			gnd_s1_r <= 1'b0;
			gnd_s2_r <= 1'b0;
		end else begin
			tie_s1_r <= pwm_tied_high;
			tie_s2_r <= tie_s1_r;
			gnd_s1_r <= threshold_pin_gnd;
			gnd_s2_r <= gnd_s1_r;
		end
	end

	// Populated count is caught once after reset release, when the
	// synchronisers hold settled pin levels; the lowest tied PWM sets it.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			strap_cnt_r <= 2'h0;
			strap_done_r <= 1'b0;
			populated_r <= MAX_PHASE_CNT;
		end else if (!strap_done_r) begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == 2'(STRAP_DELAY_CYC - 1)) begin
				strap_done_r <= 1'b1;
				if (tie_s2_r[2]) populated_r <= 3'h2;
				else if (tie_s2_r[3]) populated_r <= 3'h3;
				else if (tie_s2_r[4]) populated_r <= 3'h4;
				else if (tie_s2_r[5]) populated_r <= 3'h5;
				else populated_r <= MAX_PHASE_CNT;
			end
		end
	end

	// Monitor reading with signed offset trim, clamped at zero.
	always_comb begin
		logic signed [12:0] sum;
		sum = 13'sd0;
		sum = $signed({3'h0, load_current_monitor}) +
			$signed({{8{monitor_offset_trim_r[TRIM_MSB]}}, monitor_offset_trim_r});
		monitor_trim = sum[12] ? 12'h000 : sum[11:0];
	end

	// Mode decode and the floor and target phase counts.
	always_comb begin
		auto_on = !mode_control_r[MODE_AUTO_DIS_BIT] && !gnd_s2_r;
		restore_all = ocp_retry ||
			(transient_phase_add && !mode_control_r[MODE_APA_DIS_BIT]);
		min_phases = (phase_shed_config_r.min_sel != 2'h0) ?
			{1'b0, phase_shed_config_r.min_sel} : {1'b0, low_power_phase_count};
		if (min_phases == 3'h0) min_phases = 3'h1;
		if (min_phases > populated_r) min_phases = populated_r;
		if (phase_count_r[2:0] == 3'h0 || phase_count_r > {5'h00, populated_r}) begin
			manual_target = populated_r;
		end else begin
			manual_target = phase_count_r[2:0];
		end
	end

	phs_trip_calc u_trip (
		.cfg(phase_shed_config_r),
		.active(active_r),
		.trip(trip)
	);

	// Next phase count: restore events win, then the auto or manual rule.
	always_comb begin
		active_nxt = active_r;
		if (restore_all) begin
			active_nxt = populated_r;
		end else if (!soft_start_done) begin
			active_nxt = populated_r;
		end else if (auto_on) begin
			if (dwell_r == 5'h00) begin
				if (monitor_trim > trip.up_trip && active_r < populated_r) begin
					active_nxt = active_r + 3'h1;
				end else if (monitor_trim < trip.down_trip && active_r > min_phases) begin
					active_nxt = active_r - 3'h1;
				end
			end
		end else if (manual_target < active_r) begin
			// Manual mode only sheds; raising the count waits for a restore.
			active_nxt = manual_target;
		end
		if (active_nxt > populated_r) active_nxt = populated_r;
	end

	// Active count and a dwell timer so each auto-shedding step settles before the next.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			active_r <= MAX_PHASE_CNT;
			dwell_r <= 5'h00;
		end else begin
			active_r <= active_nxt;
			if (active_nxt != active_r) dwell_r <= 5'(SHED_DWELL_CYC - 1);
			else if (dwell_r != 5'h00) dwell_r <= dwell_r - 5'h01;
		end
	end

	// Boot refresh timebase, stopped while the reference is low.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			refresh_cnt_r <= 9'h000;
		end else if (dac_mv <= REFRESH_OFF_MV) begin
			refresh_cnt_r <= 9'h000;
		end else if (refresh_cnt_r == 9'(REFRESH_PERIOD_CYC - 1)) begin
			refresh_cnt_r <= 9'h000;
		end else begin
			refresh_cnt_r <= refresh_cnt_r + 9'h001;
		end
	end

	assign refresh_pulse = (refresh_cnt_r < 9'(REFRESH_PULSE_CYC)) &&
		(dac_mv > REFRESH_OFF_MV) && strap_done_r;

	// Drop-order rank of a phase for a populated count; lower ranks go first.
	function automatic logic [2:0] drop_rank(input logic [2:0] pop, input int ph);
		logic [2:0] r;
		r = 3'h0;
		unique case (pop)
			3'h6: r = (ph == 0) ? 3'h5 : (ph == 1) ? 3'h3 : (ph == 2) ? 3'h1 :
				(ph == 3) ? 3'h4 : (ph == 4) ? 3'h2 : 3'h0;
			3'h5: r = (ph == 0) ? 3'h4 : (ph == 1) ? 3'h2 : (ph == 2) ? 3'h3 :
				(ph == 3) ? 3'h1 : 3'h0;
			3'h4: r = (ph == 0) ? 3'h3 : (ph == 1) ? 3'h1 : (ph == 2) ? 3'h2 : 3'h0;
			3'h3: r = (ph == 0) ? 3'h2 : (ph == 1) ? 3'h1 : 3'h0;
			default: r = (ph == 0) ? 3'h1 : 3'h0;
		endcase
		return r;
	endfunction

	// Per-phase enable and refresh; a phase runs while its rank survives.
	genvar gi;
	generate
		for (gi = 0; gi < MAX_PHASES; gi++) begin : g_phase
			logic present;
			logic keep;
			assign present = (gi < populated_r);
			assign keep = present && (drop_rank(populated_r, gi) >= populated_r - active_r);
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					phase_enable[gi] <= 1'b0;
					low_side_refresh[gi] <= 1'b0;
				end else begin
					phase_enable[gi] <= keep;
					low_side_refresh[gi] <= present && !keep && refresh_pulse;
				end
			end
		end
	endgenerate

	// Checks on the design's own behaviour.
	a_floor_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
		(soft_start_done && !restore_all && auto_on && $past(active_r) >= min_phases) |->
		(active_r >= min_phases)) else $error("shed below minimum phase count");
	a_restore_all: assert property (@(posedge clk_sys) disable iff (!rstn)
		(transient_phase_add && !mode_control_r[MODE_APA_DIS_BIT]) |=> (active_r == populated_r))
		else $error("transient add did not restore all phases");
	a_manual_noadd: assert property (@(posedge clk_sys) disable iff (!rstn)
		(soft_start_done && !auto_on && !restore_all && strap_done_r && $past(strap_done_r))
		|=> (active_r <= $past(active_r))) else $error("manual mode added a phase");
	a_auto_gnd_off: assert property (@(posedge clk_sys) disable iff (!rstn)
		(gnd_s2_r && soft_start_done && !restore_all) |=> (active_r <= $past(active_r)))
		else $error("grounded pin left auto shedding on");
	a_drop_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
		(soft_start_done && auto_on && !restore_all && active_nxt < active_r) |->
		(monitor_trim < trip.down_trip)) else $error("phase dropped above drop trip");
	a_add_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
		(soft_start_done && auto_on && !restore_all && active_nxt > active_r) |->
		(monitor_trim > trip.up_trip)) else $error("phase added below add trip");
	a_refresh_low_dac: assert property (@(posedge clk_sys) disable iff (!rstn)
		(dac_mv <= REFRESH_OFF_MV) [*2] |-> (low_side_refresh == '0))
		else $error("boot refresh ran with low reference");
	a_refresh_dropped: assert property (@(posedge clk_sys) disable iff (!rstn)
		(low_side_refresh & phase_enable) == '0) else $error("refresh on a running phase");
	a_refresh_period: assert property (@(posedge clk_sys) disable iff (!rstn)
		(refresh_cnt_r == 9'h000 && dac_mv > REFRESH_OFF_MV) [*1] ##1
		(dac_mv > REFRESH_OFF_MV) [*8] |-> (refresh_cnt_r == 9'h008))
		else $error("refresh timebase not counting");
	a_order_six: assert property (@(posedge clk_sys) disable iff (!rstn)
		(populated_r == 3'h6 && active_r == 3'h5) |=> (!phase_enable[5] || active_r != 3'h5))
		else $error("phase six not dropped first");
endmodule // phs_auto_shed
`default_nettype wire

/* File: design/phs_pkg.sv */
// Shared constants and types for the auto phase shedding controller.
package phs_pkg;
	// Register command codes.
	localparam logic [7:0] PHASE_COUNT_OFS = 8'hd0;
	localparam logic [7:0] PHASE_SHED_CONFIG_OFS = 8'hd1;
	localparam logic [7:0] SHED_STATUS_OFS = 8'hd2;
	localparam logic [7:0] MODE_CONTROL_OFS = 8'hd4;
	localparam logic [7:0] MONITOR_OFFSET_TRIM_OFS = 8'he4;

	// Values after reset.
	localparam logic [7:0] PHASE_COUNT_RST = 8'h06;
	localparam logic [7:0] PHASE_SHED_CONFIG_RST = 8'h00;
	localparam logic [7:0] MODE_CONTROL_RST = 8'h00;
	localparam logic [7:0] MONITOR_OFFSET_TRIM_RST = 8'h00;

	// Field positions.
	localparam int MODE_APA_DIS_BIT = 0;
	localparam int MODE_AUTO_DIS_BIT = 2;
	localparam int TRIM_MSB = 4;

	// Phase counts.
	localparam int MAX_PHASES = 6;
	localparam logic [2:0] MAX_PHASE_CNT = 3'h6;

	// Timing.
	localparam int CLK_HZ = 10_000_000;
	localparam int REFRESH_HZ = 20_200;
	localparam int REFRESH_PERIOD_CYC = CLK_HZ / REFRESH_HZ;
	localparam int REFRESH_PULSE_NS = 200;
	localparam int CLK_PERIOD_NS = 100;
	localparam int REFRESH_PULSE_CYC = (REFRESH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHED_DWELL_CYC = 16;
	localparam int STRAP_DELAY_CYC = 3;

	// Reference level at or below which boot refresh stops, in millivolts.
	localparam logic [10:0] REFRESH_OFF_MV = 11'h258;

	// Trip-point scale: first trip current step, in monitor LSBs.
	localparam logic [11:0] I1_STEP = 12'h020;

	// Phase-shedding configuration layout.
	typedef struct packed {
		logic [1:0] first_trip_sel;
		logic [1:0] hyst_sel;
		logic [1:0] k_sel;
		logic [1:0] min_sel;
	} phs_cfg_t;

	// Trip thresholds for the current phase count.
	typedef struct packed {
		logic [11:0] up_trip;
		logic [11:0] down_trip;
	} phs_trip_t;
endpackage

/* File: design/phs_trip_calc.sv */
// Trip-point calculator for adding and dropping phases.
`timescale 1ns/1ps
`default_nettype none
module phs_trip_calc
	import phs_pkg::*;
(
	input wire phs_cfg_t cfg, // Phase-shedding configuration.
	input wire logic [2:0] active, // Phases now running.
	output var phs_trip_t trip // Add and drop thresholds.
);
	logic [11:0] first_trip;
	logic [11:0] step;
	logic [11:0] hyst;
	logic [11:0] drop_base;

	// Trip(N) = I1 * (1 + (N-1)/K), K a power of two so the step is a shift.
	always_comb begin
		first_trip = I1_STEP * {10'h000, cfg.first_trip_sel} + I1_STEP;
		step = first_trip >> cfg.k_sel;
		// The step count is widened first, or the top setting would wrap to zero hysteresis.
		hyst = 12'((first_trip * {9'h000, {1'b0, cfg.hyst_sel} + 3'h1}) >> 3);
		trip.up_trip = first_trip + 12'(step * {9'h000, active});
		drop_base = (active == 3'h0) ? first_trip :
			first_trip + 12'(step * {9'h000, active - 3'h1});
		// Saturate so a large hysteresis cannot wrap into a huge threshold.
		trip.down_trip = (drop_base > hyst) ? drop_base - hyst : 12'h000;
	end
endmodule // phs_trip_calc
`default_nettype wire

/* File: bench/phs_stage_model.sv */
// Behavioural model of the per-phase drivers and power stages.
`timescale 1ns/1ps
`default_nettype none
module phs_stage_model
	import phs_pkg::*;
#(
	parameter int POPULATED = 6
)(
	input wire logic clk_sys, // System clock.
	input wire logic rstn, // Reset, active low.
	input wire logic [MAX_PHASES-1:0] phase_enable, // Phases switching.
	input wire logic [MAX_PHASES-1:0] low_side_refresh, // Low-side refresh pulses.
	output logic [MAX_PHASES-1:0] pwm_tied_high, // Strap seen on the PWM pins.
	output logic stage_fault // Sticky flag for a refresh on a running phase.
);
	// The first unused PWM pin is tied to the supply; a full board ties none.
	assign pwm_tied_high = MAX_PHASES'(1 << POPULATED);

	// A low-side pulse on a switching phase would fight its own high side, so flag it.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stage_fault <= 1'b0;
		end else if (|(low_side_refresh & phase_enable)) begin
			stage_fault <= 1'b1;
		end
	end
endmodule // phs_stage_model
`default_nettype wire

/* File: bench/phs_auto_shed_test.sv */
// Self-checking testbench for the auto phase shedding controller.
`timescale 1ns/1ps
`default_nettype none
module phs_auto_shed_test
	import phs_pkg::*;
;
	logic clk_sys, rstn, reg_wr, thr_gnd, soft_done, apa_pulse, ocp_pulse, stage_fault;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [9:0] load;
	logic [10:0] dac;
	logic [MAX_PHASES-1:0] tied, phase_enable, refresh;
	logic [1:0] lpc;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;

	phs_auto_shed i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .load_current_monitor(load),
		.low_power_phase_count(lpc), .threshold_pin_gnd(thr_gnd), .pwm_tied_high(tied),
		.soft_start_done(soft_done), .transient_phase_add(apa_pulse), .ocp_retry(ocp_pulse),
		.dac_mv(dac), .phase_enable(phase_enable), .low_side_refresh(refresh));
	phs_stage_model #(.POPULATED(6)) i_stage (.clk_sys(clk_sys), .rstn(rstn),
		.phase_enable(phase_enable), .low_side_refresh(refresh), .pwm_tied_high(tied),
		.stage_fault(stage_fault));

	// Free-running 10 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// A hang is cut short well past the expected run length.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			$display("[ERR] %0t run timed out", $time);
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// One-cycle overcurrent retry pulse; it brings back every populated phase.
	task automatic retry();
		@(posedge clk_sys);
		ocp_pulse <= 1'b1;
		@(posedge clk_sys);
		ocp_pulse <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// Read data is registered, so it is judged one edge after the address is set.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk_sys);
		reg_addr <= a;
		@(posedge clk_sys);
		@(negedge clk_sys);
		check(16'(reg_rdata), 16'(exp), what);
	endtask

	task automatic phases(input logic [5:0] exp, input string what);
		@(negedge clk_sys);
		check(16'(phase_enable), 16'(exp), what);
	endtask

	// Waits at falling edges for refresh of phase six to reach a level, bounded.
	task automatic wait_level(input logic lvl);
		int k;
		k = 0;
		while (refresh[5] !== lvl && k < 600) begin
			@(negedge clk_sys);
			k++;
		end
	endtask

	task automatic t_regs();
		rd(8'hd0, 8'h06, "phase count reset");
		rd(8'hd1, 8'h00, "shed config reset");
		rd(8'hd4, 8'h00, "mode reset");
		rd(8'he4, 8'h00, "trim reset");
		wr(8'h55, 8'ha5);
		rd(8'h55, 8'h00, "unmapped read");
		wr(8'he4, 8'hff);
		rd(8'he4, 8'h1f, "trim width");
		wr(8'hd1, 8'hb6);
		rd(8'hd1, 8'hb6, "shed config fields");
		wr(8'he4, 8'h00);
		wr(8'hd1, 8'h00);
		$display("test regs done");
	endtask

	// Counts kept in manual mode follow the tail of the six-phase drop order 6,3,5,2,4,1.
	task automatic t_manual();
		logic [5:0] keep [1:6];
		keep = '{6'h01, 6'h09, 6'h0b, 6'h1b, 6'h1f, 6'h3f};
		wr(8'hd4, 8'h04);
		// Auto shedding ran since soft-start, and manual mode never raises the count.
		wr(8'hd0, 8'h06);
		retry();
		for (int n = 6; n >= 1; n--) begin
			wr(8'hd0, 8'(n));
			waitc(4);
			phases(keep[n], "manual count");
		end
		$display("test manual done");
	endtask

	task automatic t_refresh();
		int t0;
		int k;
		wait_level(1'b0);
		wait_level(1'b1);
		t0 = cycles;
		wait_level(1'b0);
		check(16'(cycles - t0), 16'd2, "refresh width");
		wait_level(1'b1);
		check(16'(cycles - t0), 16'd495, "refresh period");
		dac <= 11'd600;
		waitc(3);
		k = 0;
		repeat (1000) begin
			@(negedge clk_sys);
			if (refresh !== 6'h00) k++;
		end
		check(16'(k), 16'd0, "refresh at low reference");
		dac <= 11'd1000;
		$display("test refresh done");
	endtask

	task automatic t_restore();
		logic seen;
		wr(8'hd4, 8'h05);
		wr(8'hd0, 8'h03);
		waitc(6);
		phases(6'h01, "manual rise refused");
		@(posedge clk_sys) apa_pulse <= 1'b1;
		@(posedge clk_sys) apa_pulse <= 1'b0;
		waitc(6);
		phases(6'h01, "transient add while disabled");
		@(posedge clk_sys) ocp_pulse <= 1'b1;
		@(posedge clk_sys) ocp_pulse <= 1'b0;
		waitc(6);
		phases(6'h0b, "retry restores then drops");
		wr(8'hd4, 8'h04);
		wr(8'hd0, 8'h01);
		waitc(6);
		@(posedge clk_sys) apa_pulse <= 1'b1;
		@(posedge clk_sys) apa_pulse <= 1'b0;
		seen = 1'b0;
		repeat (6) begin
			@(negedge clk_sys);
			if (phase_enable === 6'h3f) seen = 1'b1;
		end
		check(16'(seen), 16'h1, "transient add restores all");
		$display("test restore done");
	endtask

	task automatic t_auto();
		wr(8'hd0, 8'h03);
		wr(8'hd1, 8'h03);
		wr(8'hd4, 8'h00);
		// Start from all phases so the shed walks down to the programmed floor.
		retry();
		load <= 10'h000;
		waitc(200);
		phases(6'h0b, "shed to programmed minimum");
		lpc <= 2'h2;
		wr(8'hd1, 8'h00);
		waitc(40);
		phases(6'h09, "shed to minimum");
		load <= 10'h3ff;
		waitc(200);
		phases(6'h3f, "add at heavy load");
		load <= 10'h000;
		thr_gnd <= 1'b1;
		waitc(10);
		phases(6'h0b, "grounded pin forces manual");
		rd(8'hd2, 8'h33, "status with grounded pin");
		thr_gnd <= 1'b0;
		$display("test auto done");
	endtask

	// Main sequence: reset, then each scenario in turn.
	initial begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		thr_gnd = 1'b0;
		soft_done = 1'b0;
		apa_pulse = 1'b0;
		ocp_pulse = 1'b0;
		load = 10'h000;
		lpc = 2'h1;
		dac = 11'd1000;
		waitc(3);
		rstn <= 1'b1;
		waitc(5);
		phases(6'h3f, "all run before soft-start");
		soft_done <= 1'b1;
		t_regs();
		t_manual();
		t_refresh();
		t_restore();
		t_auto();
		check(16'(stage_fault), 16'h0, "refresh only on dropped phases");
		close_out();
	end
endmodule // phs_auto_shed_test
`default_nettype wire
